// File: src/ussp_port.v
// Notes on behaviour
// - Shift register is unbuffered; next transfer overwrites it.
// - Top bit reaches the output pin through a latch, opposite edge.
// - Serial input always comes from the data-in pin.
// - Four-bit counter, CPU readable and writable, clocked with shift register.
// - External clock makes the counter count both edges, or TC strobes when the CLK bit is set.
// - Clock source is clock pin, timer zero overflow or software strobe.
// - Two-wire mode with the clock direction bit set holds clock low after start or counter overflow.
// - CPU write to data beats a same-cycle shift; shift is skipped.
// - Each shift clock moves the register one place toward the top bit.
// - Disabled wire mode still lets pin clock and data feed the register.
// - Latch open first half-period on external clock, always on internal.
// - Status flags clear on written one; use full-byte writes.
// - Two-wire mode sets start flag on a detected start condition.
// - Off or three-wire, external clock, no strobe: any clock edge sets start.
// - Start request when flag, enable and global enable; wakes any sleep.
// - Start flag clears on written one; this releases start clock hold.
// - Overflow flag set on counter wrap 15 to 0; may request interrupt.
// - Overflow flag clears on written one; this releases overflow hold.
// - Overflow event wakes only from idle sleep.
// - Two-wire stop sets stop flag; cleared by one; no interrupt.
// - Wire mode 00 off, 01 three-wire, 10 two-wire open drain.
// - Collision bit reads one when top bit differs from data pin.
`timescale 1ns/10ps
`default_nettype none
`include "ussp_regs.vh"

module ussp_port (
    input  wire                   CLOCK,
    input  wire                   SRST,
    input  wire [`USSP_ADDR_W-1:0] IO_ADDR,
    input  wire [7:0]             IO_WDATA,
    input  wire                   IO_WE,
    output reg  [7:0]             IO_RDATA,
    input  wire                   TIMER0_OVF,
    input  wire                   GLOBAL_IE,
    input  wire                   SLEEP_IDLE,
    input  wire                   PIN_DIR_DATA,
    input  wire                   PIN_DIR_CLOCK,
    input  wire                   PORT_DATA,
    input  wire                   PORT_CLOCK,
    input  wire                   DI_IN,
    input  wire                   SCK_IN,
    output reg                    DO_OUT,
    output reg                    DO_OE_N,
    output reg                    SDA_OUT,
    output reg                    SDA_OE_N,
    output reg                    SCL_OUT,
    output reg                    SCL_OE_N,
    output reg                    START_IRQ,
    output reg                    OVF_IRQ,
    output reg                    START_WAKE,
    output reg                    OVF_WAKE
);

    // Register state
    reg [7:0] shift_data_register;
    reg [3:0] bit_edge_counter;
    reg       start_condition_flag;
    reg       counter_overflow_flag;
    reg       stop_condition_flag;
    reg       start_interrupt_enable;
    reg       overflow_interrupt_enable;
    reg [1:0] wire_mode_field;
    reg [1:0] clock_select_field;
    reg       clock_strobe_bit;
    reg       out_latch;

    // Synchronised pins and their previous values
    wire [`USSP_SYNC_W-1:0] pins_sync;
    reg                     sck_prev;
    reg                     di_prev;

    // Decode and helper nets
    wire       sck_s;
    wire       di_s;
    wire       sck_rise;
    wire       sck_fall;
    wire       sck_edge;
    wire       di_rise;
    wire       di_fall;
    wire       wr_status;
    wire       wr_data;
    wire       wr_control;
    wire       ext_clock;
    wire       soft_strobe;
    wire       tc_strobe;
    wire       shift_tick;
    wire       count_tick;
    wire       two_wire;
    wire       start_seen;
    wire       stop_seen;
    wire       edge_start;
    wire       wrap;
    wire       collision;
    wire       latch_open;
    wire       clock_hold;
    wire [7:0] status_value;
    wire [7:0] control_value;
    reg  [7:0] next_rdata;

    // Both pins pass two flip-flops before any edge logic reads them
    ussp_sync #(
        .WIDTH    (`USSP_SYNC_W)
    ) ussp_sync_inst (
        .clk      (CLOCK),
        .srst     (SRST),
        .async_in ({SCK_IN, DI_IN}),
        .sync_out (pins_sync)
    );

    assign sck_s = pins_sync[1];
    assign di_s  = pins_sync[0];

    // Previous sample for edge detection, taken after the synchroniser
    always @(posedge CLOCK) begin
        if (SRST) begin
            sck_prev <= 1'b0;
            di_prev  <= 1'b0;
        end else begin
            sck_prev <= sck_s;
            di_prev  <= di_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev;
    assign sck_fall = ~sck_s & sck_prev;
    assign sck_edge = sck_rise | sck_fall;
    assign di_rise  = di_s & ~di_prev;
    assign di_fall  = ~di_s & di_prev;

    // Address decode on the I/O port
    assign wr_status  = IO_WE & (IO_ADDR == `USSP_ADDR_STATUS);
    assign wr_data    = IO_WE & (IO_ADDR == `USSP_ADDR_DATA);
    assign wr_control = IO_WE & (IO_ADDR == `USSP_ADDR_CONTROL);

    // Software strobes come from control writes; TC is never stored, CLK also sets clock_strobe_bit
    assign soft_strobe = wr_control & IO_WDATA[`USSP_CT_CLK];
    assign tc_strobe   = wr_control & IO_WDATA[`USSP_CT_TC];

    assign ext_clock = clock_select_field[1];

    // shift clock from the chosen source and edge
    assign shift_tick =
        (clock_select_field == `USSP_CS_SOFT)    ? soft_strobe :
        (clock_select_field == `USSP_CS_TIMER)   ? TIMER0_OVF  :
        (clock_select_field == `USSP_CS_EXT_POS) ? sck_rise    :
                                                   sck_fall;

    // external clock counts both edges, or the strobe when enabled
    assign count_tick = ext_clock ?
        (clock_strobe_bit ? tc_strobe : sck_edge) : shift_tick;

    // counter wrap marks a completed transfer
    assign wrap = count_tick & (bit_edge_counter == `USSP_CNT_MAX);

    assign two_wire = (wire_mode_field == `USSP_WM_TWO);

    // start and stop seen while the clock line is high
    assign start_seen = two_wire & sck_s & sck_prev & di_fall;
    assign stop_seen  = two_wire & sck_s & sck_prev & di_rise;

    // edge counts as start outside two-wire mode
    assign edge_start = ~two_wire & ext_clock & ~clock_strobe_bit & sck_edge;

    // top bit against the real data pin
    assign collision = shift_data_register[7] ^ di_s;

    // latch opens in the half-period before the sampling edge
    assign latch_open = ~ext_clock | (sck_s == clock_select_field[0]);

    // hold clock low while a start or overflow flag is pending
    assign clock_hold = two_wire &
        (start_condition_flag | counter_overflow_flag);

    assign status_value = {start_condition_flag, counter_overflow_flag,
                           stop_condition_flag, collision,
                           bit_edge_counter};

    // The TC strobe bit reads as zero; the CLK bit reads back from clock_strobe_bit
    assign control_value = {start_interrupt_enable,
                            overflow_interrupt_enable,
                            wire_mode_field, clock_select_field,
                            clock_strobe_bit, 1'b0};

    // Control register; the software strobes are taken separately
    always @(posedge CLOCK) begin
        if (SRST) begin
            start_interrupt_enable    <= 1'b0;
            overflow_interrupt_enable <= 1'b0;
            wire_mode_field           <= `USSP_WM_OFF;
            clock_select_field        <= `USSP_CS_SOFT;
            clock_strobe_bit          <= 1'b0;
        end else if (wr_control) begin
            start_interrupt_enable    <= IO_WDATA[`USSP_CT_SIE];
            overflow_interrupt_enable <= IO_WDATA[`USSP_CT_OIE];
            wire_mode_field   <= IO_WDATA[`USSP_CT_WM_HI:`USSP_CT_WM_LO];
            clock_select_field <= IO_WDATA[`USSP_CT_CS_HI:`USSP_CT_CS_LO];
            clock_strobe_bit  <= IO_WDATA[`USSP_CT_CLK];
        end
    end

    // Shift register: no holding buffer, software must keep up
    always @(posedge CLOCK) begin
        if (SRST) begin
            shift_data_register <= `USSP_RST_DATA;
        end else if (wr_data) begin
            shift_data_register <= IO_WDATA;
        end else if (shift_tick) begin
            shift_data_register <= {shift_data_register[6:0], di_s};
        end
    end

    // Counter runs in every wire mode, including off
    always @(posedge CLOCK) begin
        if (SRST) begin
            bit_edge_counter <= `USSP_RST_CNT;
        end else if (wr_status) begin
            bit_edge_counter <= IO_WDATA[`USSP_ST_CNT_HI:`USSP_ST_CNT_LO];
        // pins count even when outputs are off
        end else if (count_tick) begin
            bit_edge_counter <= bit_edge_counter + `USSP_CNT_ONE;
        end
    end

    // Flags: a same-cycle event beats the clearing write
    always @(posedge CLOCK) begin
        if (SRST) begin
            start_condition_flag  <= 1'b0;
            counter_overflow_flag <= 1'b0;
            stop_condition_flag   <= 1'b0;
        end else begin
            if (start_seen | edge_start) begin
                start_condition_flag <= 1'b1;
            end else if (wr_status & IO_WDATA[`USSP_ST_START]) begin
                start_condition_flag <= 1'b0;
            end
            if (wrap) begin
                counter_overflow_flag <= 1'b1;
            end else if (wr_status & IO_WDATA[`USSP_ST_OVF]) begin
                counter_overflow_flag <= 1'b0;
            end
            if (stop_seen) begin
                stop_condition_flag <= 1'b1;
            end else if (wr_status & IO_WDATA[`USSP_ST_STOP]) begin
                stop_condition_flag <= 1'b0;
            end
        end
    end

    // output latch tracks the top bit only while open
    always @(posedge CLOCK) begin
        if (SRST) begin
            out_latch <= 1'b0;
        end else if (latch_open) begin
            out_latch <= shift_data_register[7];
        end
    end

    // Read data mux, registered so the port answers one cycle later
    always @* begin
        next_rdata = `USSP_BYTE_ZERO;
        case (IO_ADDR)
            `USSP_ADDR_STATUS:  next_rdata = status_value;
            `USSP_ADDR_DATA:    next_rdata = shift_data_register;
            `USSP_ADDR_CONTROL: next_rdata = control_value;
            default:            next_rdata = `USSP_BYTE_ZERO;
        endcase
    end

    always @(posedge CLOCK) begin
        if (SRST) begin
            IO_RDATA <= `USSP_BYTE_ZERO;
        end else begin
            IO_RDATA <= next_rdata;
        end
    end

    // Pin drivers; enables are low while the pin is driven
    always @(posedge CLOCK) begin
        if (SRST) begin
            DO_OUT   <= 1'b0;
            DO_OE_N  <= 1'b1;
            SDA_OUT  <= 1'b0;
            SDA_OE_N <= 1'b1;
            SCL_OUT  <= 1'b0;
            SCL_OE_N <= 1'b1;
        end else begin
            DO_OUT  <= out_latch;
            DO_OE_N <= ~((wire_mode_field == `USSP_WM_THREE) &
                         PIN_DIR_DATA);
            // Open drain: only ever pulls low
            SDA_OUT  <= 1'b0;
            SDA_OE_N <= ~(two_wire & PIN_DIR_DATA &
                          (~out_latch | ~PORT_DATA));
            SCL_OUT  <= 1'b0;
            // clock hold pulls the clock line low
            SCL_OE_N <= ~(two_wire & PIN_DIR_CLOCK &
                          (~PORT_CLOCK | clock_hold));
        end
    end

    // Interrupt requests and wake-up levels
    always @(posedge CLOCK) begin
        if (SRST) begin
            START_IRQ  <= 1'b0;
            OVF_IRQ    <= 1'b0;
            START_WAKE <= 1'b0;
            OVF_WAKE   <= 1'b0;
        end else begin
            // start request and wake from any sleep
            START_IRQ  <= start_condition_flag & start_interrupt_enable &
                          GLOBAL_IE;
            START_WAKE <= start_condition_flag & start_interrupt_enable;
            OVF_IRQ    <= counter_overflow_flag &
                          overflow_interrupt_enable & GLOBAL_IE;
            OVF_WAKE   <= counter_overflow_flag &
                          overflow_interrupt_enable & SLEEP_IDLE;
        end
    end

endmodule

`default_nettype wire

// File: src/ussp_regs.vh
`ifndef USSP_REGS_VH
`define USSP_REGS_VH

// Register addresses on the I/O port
`define USSP_ADDR_W          6
`define USSP_ADDR_STATUS     6'h0e
`define USSP_ADDR_DATA       6'h0f
`define USSP_ADDR_CONTROL    6'h0d

// Status register fields
`define USSP_ST_START        7
`define USSP_ST_OVF          6
`define USSP_ST_STOP         5
`define USSP_ST_COLL         4
`define USSP_ST_CNT_HI       3
`define USSP_ST_CNT_LO       0

// Control register fields
`define USSP_CT_SIE          7
`define USSP_CT_OIE          6
`define USSP_CT_WM_HI        5
`define USSP_CT_WM_LO        4
`define USSP_CT_CS_HI        3
`define USSP_CT_CS_LO        2
`define USSP_CT_CLK          1
`define USSP_CT_TC           0

// Reset values
`define USSP_RST_STATUS      8'h00
`define USSP_RST_DATA        8'h00
`define USSP_RST_CONTROL     8'h00
`define USSP_RST_CNT         4'h0
`define USSP_CNT_MAX         4'hf
`define USSP_CNT_ONE         4'h1
`define USSP_BYTE_ZERO       8'h00

// Wire modes
`define USSP_WM_OFF          2'h0
`define USSP_WM_THREE        2'h1
`define USSP_WM_TWO          2'h2

// Clock select codes
`define USSP_CS_SOFT         2'h0
`define USSP_CS_TIMER        2'h1
`define USSP_CS_EXT_POS      2'h2
`define USSP_CS_EXT_NEG      2'h3

// Synchroniser width: clock pin and data pin
`define USSP_SYNC_W          2

`endif

// File: src/ussp_sync.v
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for pins from outside the clock domain
module ussp_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage;

    // First stage feeds only the second one
    always @(posedge clk) begin
        if (srst) begin
            stage    <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end

endmodule

`default_nettype wire

// File: tb/tb_ussp_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "ussp_regs.vh"

module tb_ussp_port;
    localparam logic [5:0] ST = `USSP_ADDR_STATUS;
    localparam logic [5:0] DT = `USSP_ADDR_DATA;
    localparam logic [5:0] CT = `USSP_ADDR_CONTROL;
    logic       CLOCK = 1'b0;
    logic       SRST = 1'b1;
    logic [5:0] IO_ADDR = 6'h00;
    logic [7:0] IO_WDATA = 8'h00;
    logic       IO_WE = 1'b0;
    logic       TIMER0_OVF = 1'b0;
    logic       GLOBAL_IE = 1'b1;
    logic       SLEEP_IDLE = 1'b1;
    logic       PIN_DIR_DATA = 1'b0;
    logic       PIN_DIR_CLOCK = 1'b0;
    logic       PORT_DATA = 1'b1;
    logic       PORT_CLOCK = 1'b1;
    logic [7:0] IO_RDATA;
    logic       DO_OUT, DO_OE_N, SDA_OUT, SDA_OE_N, SCL_OUT, SCL_OE_N;
    logic       START_IRQ, OVF_IRQ, START_WAKE, OVF_WAKE;
    wire logic  DI_IN, SCK_IN;
    int         n_errors = 0;
    int         compares = 0;
    int         cyc = 0;
    logic [1:0] wm;
    logic       di;
    logic [7:0] ini, exp;
    // Row: wire mode, data-in level, start data, data after one strobe
    logic [18:0] rows [3] = '{{2'h0, 1'b1, 8'h81, 8'h03},
        {2'h1, 1'b0, 8'h5a, 8'hb4}, {2'h2, 1'b1, 8'hc3, 8'h87}};

    ussp_port ussp_port_inst (.*);
    ussp_peer ussp_peer_inst (.*);

    // System clock, 8 ns period
    always #4 CLOCK = ~CLOCK;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WE = 1'b1;
        @(negedge CLOCK);
        IO_WE = 1'b0;
    endtask
    // Read data shows one edge after the address
    task automatic chk(input logic [5:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        @(negedge CLOCK);
        IO_ADDR = a;
        @(negedge CLOCK);
        cmp(IO_RDATA & m, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge CLOCK);
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        idle(6);
        SRST = 1'b0;
        chk(ST, 8'hff, 8'h00);
        chk(DT, 8'hff, 8'h00);
        wr(6'h3f, 8'hff);
        chk(6'h3f, 8'hff, 8'h00);
        // Idle data-in is high against a zero top bit, so collision reads one
        chk(ST, 8'hff, 8'h10);
        $display("test reset done");
        // Soft strobe in each wire mode; input always from data-in
        foreach (rows[i]) begin
            {wm, di, ini, exp} = rows[i];
            ussp_peer_inst.sda = di;
            wr(DT, ini);
            wr(ST, 8'h00);
            wr(CT, {2'b00, wm, 4'b0010});
            chk(DT, 8'hff, exp);
            chk(ST, 8'h0f, 8'h01);
        end
        $display("test rows done");
        // Timer source wraps 15 to 0 and raises overflow
        ussp_peer_inst.sda = 1'b0;
        wr(CT, 8'h44);
        wr(ST, 8'h0f);
        wr(DT, 8'h01);
        TIMER0_OVF = 1'b1;
        idle(1);
        TIMER0_OVF = 1'b0;
        chk(DT, 8'hff, 8'h02);
        chk(ST, 8'h4f, 8'h40);
        cmp({6'h0, OVF_IRQ, OVF_WAKE}, 8'h03);
        // Global enable and idle sleep off: no request and no wake
        GLOBAL_IE = 1'b0;
        SLEEP_IDLE = 1'b0;
        idle(2);
        cmp({6'h0, OVF_IRQ, OVF_WAKE}, 8'h00);
        GLOBAL_IE = 1'b1;
        SLEEP_IDLE = 1'b1;
        wr(ST, 8'h40);
        chk(ST, 8'h40, 8'h00);
        // Data write in the cycle of a timer tick
        IO_ADDR = DT;
        IO_WDATA = 8'h3c;
        IO_WE = 1'b1;
        TIMER0_OVF = 1'b1;
        idle(1);
        IO_WE = 1'b0;
        TIMER0_OVF = 1'b0;
        chk(DT, 8'hff, 8'h3c);
        $display("test timer done");
        // Three-wire, internal clock: top bit straight to the pin
        PIN_DIR_DATA = 1'b1;
        wr(CT, 8'h10);
        wr(DT, 8'h80);
        idle(2);
        cmp({6'h0, DO_OUT, DO_OE_N}, 8'h02);
        chk(ST, 8'h10, 8'h10);
        // External rising clock: 16 edges per byte, any edge flags start
        wr(ST, 8'hf0);
        wr(CT, 8'h18);
        ussp_peer_inst.send(8'ha6);
        idle(5);
        chk(DT, 8'hff, 8'ha6);
        chk(ST, 8'hcf, 8'hc0);
        // Falling source with strobe bit set: the counter follows bit 0
        wr(CT, 8'h1e);
        wr(CT, 8'h1f);
        chk(ST, 8'h0f, 8'h01);
        $display("test three-wire done");
        // Two-wire: start holds clock low until the flag is cleared
        PIN_DIR_DATA = 1'b0;
        PIN_DIR_CLOCK = 1'b1;
        ussp_peer_inst.sda = 1'b1;
        wr(ST, 8'hf0);
        wr(CT, 8'ha8);
        ussp_peer_inst.cond(1'b0);
        idle(5);
        chk(ST, 8'h80, 8'h80);
        cmp({6'h0, SCL_OE_N, START_IRQ}, 8'h01);
        wr(ST, 8'h80);
        idle(2);
        cmp({7'h0, SCL_OE_N}, 8'h01);
        ussp_peer_inst.cond(1'b1);
        idle(5);
        chk(ST, 8'ha0, 8'h20);
        // Cleared port bits pull both open-drain lines low
        PORT_CLOCK = 1'b0;
        PORT_DATA = 1'b0;
        PIN_DIR_DATA = 1'b1;
        idle(2);
        cmp({6'h0, SCL_OE_N, SDA_OE_N}, 8'h00);
        $display("test two-wire done");
        results();
    end
endmodule
`default_nettype wire

// File: tb/ussp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "ussp_regs.vh"

// Port checks on enables, requests and register read-back
module ussp_monitor (
    input wire logic       CLOCK,
    input wire logic       SRST,
    input wire logic [5:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic       IO_WE,
    input wire logic [7:0] IO_RDATA,
    input wire logic       TIMER0_OVF,
    input wire logic       GLOBAL_IE,
    input wire logic       SLEEP_IDLE,
    input wire logic       PIN_DIR_DATA,
    input wire logic       PIN_DIR_CLOCK,
    input wire logic       DO_OE_N,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE_N,
    input wire logic       SCL_OUT,
    input wire logic       SCL_OE_N,
    input wire logic       START_IRQ,
    input wire logic       OVF_IRQ,
    input wire logic       START_WAKE,
    input wire logic       OVF_WAKE
);
    default clocking mcb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    // Reset itself must release every pin, so it is not disabled by it
    property p_rst_idle;
        disable iff (1'b0) SRST |=> DO_OE_N && SDA_OE_N && SCL_OE_N
            && !START_IRQ && !OVF_IRQ;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("pins or requests active after reset");
    property p_od_low;
        SDA_OUT == 1'b0 && SCL_OUT == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain output value not low");
    property p_one_mode;
        !DO_OE_N |-> SDA_OE_N && SCL_OE_N;
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("three-wire and two-wire pins driven together");
    property p_start_gie;
        START_IRQ |-> $past(GLOBAL_IE) && START_WAKE;
    endproperty
    a_start_gie: assert property (p_start_gie)
        else $error("start request without enable or wake");
    property p_ovf_gie;
        OVF_IRQ |-> $past(GLOBAL_IE);
    endproperty
    a_ovf_gie: assert property (p_ovf_gie)
        else $error("overflow request with global enable off");
    property p_ovf_wake;
        OVF_WAKE |-> $past(SLEEP_IDLE);
    endproperty
    a_ovf_wake: assert property (p_ovf_wake)
        else $error("overflow wake outside idle sleep");
    property p_scl_dir;
        !SCL_OE_N |-> $past(PIN_DIR_CLOCK);
    endproperty
    a_scl_dir: assert property (p_scl_dir)
        else $error("clock line held with direction bit clear");
    property p_sda_dir;
        !SDA_OE_N |-> $past(PIN_DIR_DATA);
    endproperty
    a_sda_dir: assert property (p_sda_dir)
        else $error("data line pulled with direction bit clear");
    property p_wr_wins;
        IO_WE && IO_ADDR == `USSP_ADDR_DATA && TIMER0_OVF
            ##1 IO_ADDR == `USSP_ADDR_DATA && !TIMER0_OVF
            |=> IO_RDATA == $past(IO_WDATA, 2);
    endproperty
    a_wr_wins: assert property (p_wr_wins)
        else $error("written data lost to same-cycle shift");
    c_start: cover property (START_IRQ);
    c_ovf: cover property (OVF_IRQ);
    c_hold: cover property (!SCL_OE_N);
endmodule

bind ussp_port ussp_monitor ussp_monitor_inst (.*);
`default_nettype wire

// File: tb/ussp_peer.sv
`timescale 1ns/10ps
`default_nettype none

// Bus peer: drives clock and data, lines pulled up when released
module ussp_peer (
    input  wire logic SDA_OE_N,
    input  wire logic SCL_OE_N,
    output wire logic DI_IN,
    output wire logic SCK_IN
);
    logic sda = 1'b1;
    logic scl = 1'b0;

    // Wired-and with the device's pull-downs
    assign DI_IN  = sda & SDA_OE_N;
    assign SCK_IN = scl & SCL_OE_N;

    // MSB first, data set while clock low; a 125 ns period stays inside
    // the three-wire slave limit of system/4
    // rate kept
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #62.5 scl = 1'b1;
            #62.5 scl = 1'b0;
        end
        sda = ~sda; // No stale bit left once the frame ends
    endtask

    // Data edge while clock high: falling is start, rising is stop
    // condition form
    task automatic cond(input logic rise);
        sda = ~rise;
        #62.5 scl = 1'b1;
        #62.5 sda = rise;
        #62.5 scl = rise;
    endtask
endmodule
`default_nettype wire
